// ===== arf_pkg.sv
// Package: register map, field positions and timing for the result formatter
package arf_pkg;
	// Word addresses on the register bus
	localparam logic [3:0] ADDR_CONTROL = 4'h0;
	localparam logic [3:0] ADDR_CONFIG = 4'h1;
	localparam logic [3:0] ADDR_RESULT_HIGH = 4'h2;
	localparam logic [3:0] ADDR_RESULT_LOW = 4'h3;
	localparam logic [3:0] ADDR_IRQ_STATUS = 4'h4;
	localparam logic [3:0] ADDR_IRQ_MASK = 4'h5;
	// Control register fields
	localparam int CTRL_ENABLE_BIT = 0;
	localparam int CTRL_GO_BIT = 1;
	localparam int CTRL_CHAN_LSB = 2;
	localparam int CTRL_CHAN_MSB = 6;
	// Config register fields
	localparam int CFG_JUSTIFY_BIT = 7;
	localparam logic [7:0] CFG_WRITE_MASK = 8'hf7;
	localparam logic [7:0] CTRL_WRITE_MASK = 8'h7f;
	// Interrupt status bits
	localparam int IRQ_DONE_BIT = 0;
	localparam logic [7:0] IRQ_IMPL_MASK = 8'h01;
	// Result width and code count
	localparam int RESULT_BITS = 10;
	localparam int RESULT_CODES = 1024;
	// Conversion time
	localparam int CLK_MHZ = 250;
	localparam int CONV_TIME_NS = 200;
	localparam int CONV_CYCLES = (CONV_TIME_NS * CLK_MHZ + 999) / 1000;
	localparam logic [7:0] RESET_ZERO = 8'h00;
endpackage : arf_pkg

// ===== arf_result_if.sv
// Interface: completed result handed to the result register pair
`timescale 1ns/1ps
interface arf_result_if;
	logic load;
	logic justify_right;
	logic [9:0] value;
	modport src (output load, output justify_right, output value);
	modport dst (input load, input justify_right, input value);
endinterface : arf_result_if

// ===== arf_result_regs.sv
// Result register pair with justified load and software write
`timescale 1ns/1ps
module arf_result_regs (
	// Clock
	input wire logic clk_i,
	// Result load
	arf_result_if.dst res,
	// Software write
	input wire logic wr_high_i,
	input wire logic wr_low_i,
	input wire logic [7:0] wdata_i,
	// Register contents
	output logic [7:0] high_o,
	output logic [7:0] low_o
);
	// No reset: contents unknown after power-on and kept otherwise
	always_ff @(posedge clk_i) begin
		if (res.load) begin
			if (res.justify_right) begin
				high_o <= {6'h00, res.value[9:8]};
				low_o <= res.value[7:0];
			end else begin
				high_o <= res.value[9:2];
				low_o <= {res.value[1:0], 6'h00};
			end
		end else begin
			if (wr_high_i)
				high_o <= wdata_i;
			if (wr_low_i)
				low_o <= wdata_i;
		end
	end
endmodule : arf_result_regs

// ===== arf_top.sv
// Top: control registers, conversion sequencer, bus slave and interrupt
// Notes on behaviour
// - Left justify: result 9..2 fill high register
// - Left justify: result 1..0 in low bits 7..6
// - Right justify: result 9..8 in high bits 1..0
// - Right justify: result 7..0 fill low register
// - Result registers read-write, no reset value
// - Result is ten bits, 1024 codes
// - Unused six bits zeroed on result load
// - Go bit starts conversion, hardware clears it
`timescale 1ns/1ps
module arf_top (
	// Clock and reset
	input wire logic clk_i,
	input wire logic reset_n_i,
	// Avalon-MM slave
	input wire logic [3:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	// Converter sample
	input wire logic [9:0] sample_i,
	// Channel and interrupt
	output logic [4:0] channel_select_o,
	output logic irq_o
);
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_CONV = 2'b01,
		ST_DONE = 2'b10
	} arf_state_t;

	// Registers
	arf_state_t state_r;
	logic [7:0] ctrl_r;
	logic [7:0] cfg_r;
	logic [7:0] irq_stat_r;
	logic [7:0] irq_mask_r;
	logic [7:0] cnt_r;
	logic [9:0] samp_s1_r;
	logic [9:0] samp_s2_r;
	logic ack_r;
	// Bus decode
	logic acc;
	logic wr_en;
	logic wr_ctrl;
	logic go_set;
	logic done;
	// Read path
	logic [7:0] res_high;
	logic [7:0] res_low;
	logic [7:0] rd_mux;
	// Checker helper
	logic [7:0] conv_len_r;

	arf_result_if res_if ();

	// One wait state per access
	assign acc = (avs_read_i || avs_write_i) && !ack_r;
	assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_r;
	assign wr_en = avs_write_i && ack_r;
	assign wr_ctrl = wr_en && (avs_address_i == arf_pkg::ADDR_CONTROL);
	assign go_set = wr_ctrl && avs_writedata_i[arf_pkg::CTRL_GO_BIT]
		&& avs_writedata_i[arf_pkg::CTRL_ENABLE_BIT];
	// Completion only while enabled; a cleared enable aborts
	assign done = (state_r == ST_CONV)
		&& ctrl_r[arf_pkg::CTRL_ENABLE_BIT]
		&& (cnt_r == 8'(arf_pkg::CONV_CYCLES - 1));

	// High in the second cycle of each request
	always_ff @(posedge clk_i) begin
		if (!reset_n_i)
			ack_r <= 1'b0;
		else
			ack_r <= acc;
	end

	// Sample pins cross in through two flops
	// Code is held steady while converting, so bit skew is harmless
	always_ff @(posedge clk_i) begin
		samp_s1_r <= sample_i;
		samp_s2_r <= samp_s1_r;
	end

	// Conversion sequencer
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			state_r <= ST_IDLE;
			cnt_r <= 8'h00;
		end else begin
			case (state_r)
				ST_IDLE: begin
					cnt_r <= 8'h00;
					if (go_set && state_r == ST_IDLE)
						state_r <= ST_CONV;
				end
				ST_CONV: begin
					if (!ctrl_r[arf_pkg::CTRL_ENABLE_BIT])
						state_r <= ST_IDLE;
					else if (done)
						state_r <= ST_IDLE;
					else
						cnt_r <= cnt_r + 8'h01;
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	// Control register; hardware clears go at completion
	always_ff @(posedge clk_i) begin
		if (!reset_n_i)
			ctrl_r <= arf_pkg::RESET_ZERO;
		else begin
			if (wr_ctrl)
				ctrl_r <= avs_writedata_i[7:0] & arf_pkg::CTRL_WRITE_MASK;
			if (done || (state_r == ST_CONV
				&& !ctrl_r[arf_pkg::CTRL_ENABLE_BIT]))
				ctrl_r[arf_pkg::CTRL_GO_BIT] <= 1'b0;
			if (wr_ctrl && !avs_writedata_i[arf_pkg::CTRL_ENABLE_BIT])
				ctrl_r[arf_pkg::CTRL_GO_BIT] <= 1'b0;
		end
	end

	// Config register; bit three is not stored
	always_ff @(posedge clk_i) begin
		if (!reset_n_i)
			cfg_r <= arf_pkg::RESET_ZERO;
		else if (wr_en && avs_address_i == arf_pkg::ADDR_CONFIG)
			cfg_r <= avs_writedata_i[7:0] & arf_pkg::CFG_WRITE_MASK;
	end

	// Sticky done flag; set wins over write-one clear
	always_ff @(posedge clk_i) begin
		if (!reset_n_i)
			irq_stat_r <= arf_pkg::RESET_ZERO;
		else begin
			if (wr_en && avs_address_i == arf_pkg::ADDR_IRQ_STATUS)
				irq_stat_r <= irq_stat_r & ~avs_writedata_i[7:0];
			if (done)
				irq_stat_r[arf_pkg::IRQ_DONE_BIT] <= 1'b1;
		end
	end

	// Interrupt mask; only the done bit exists
	always_ff @(posedge clk_i) begin
		if (!reset_n_i)
			irq_mask_r <= arf_pkg::RESET_ZERO;
		else if (wr_en && avs_address_i == arf_pkg::ADDR_IRQ_MASK)
			irq_mask_r <= avs_writedata_i[7:0] & arf_pkg::IRQ_IMPL_MASK;
	end

	// Level interrupt and channel field
	assign irq_o = |(irq_stat_r & irq_mask_r);
	assign channel_select_o =
		ctrl_r[arf_pkg::CTRL_CHAN_MSB:arf_pkg::CTRL_CHAN_LSB];

	// Ten-bit result handed over at completion
	assign res_if.load = done;
	assign res_if.justify_right = cfg_r[arf_pkg::CFG_JUSTIFY_BIT];
	assign res_if.value = samp_s2_r;

	// Result pair, loaded at completion or by software
	arf_result_regs u_result (
		.clk_i(clk_i),
		.res(res_if.dst),
		.wr_high_i(wr_en && avs_address_i == arf_pkg::ADDR_RESULT_HIGH),
		.wr_low_i(wr_en && avs_address_i == arf_pkg::ADDR_RESULT_LOW),
		.wdata_i(avs_writedata_i[7:0]),
		.high_o(res_high),
		.low_o(res_low)
	);

	// Register read selection
	always_comb begin
		case (avs_address_i)
			arf_pkg::ADDR_CONTROL: rd_mux = ctrl_r;
			arf_pkg::ADDR_CONFIG: rd_mux = cfg_r;
			arf_pkg::ADDR_RESULT_HIGH: rd_mux = res_high;
			arf_pkg::ADDR_RESULT_LOW: rd_mux = res_low;
			arf_pkg::ADDR_IRQ_STATUS: rd_mux = irq_stat_r;
			arf_pkg::ADDR_IRQ_MASK: rd_mux = irq_mask_r;
			default: rd_mux = 8'h00;
		endcase
	end

	// Captured in the wait cycle, stands until the next read
	always_ff @(posedge clk_i) begin
		if (!reset_n_i)
			avs_readdata_o <= 32'h0000_0000;
		else if (acc && avs_read_i)
			avs_readdata_o <= {24'h00_0000, rd_mux};
	end

	// Cycles spent converting, watched by the length check
	always_ff @(posedge clk_i) begin
		if (!reset_n_i)
			conv_len_r <= 8'h00;
		else if (state_r == ST_CONV)
			conv_len_r <= conv_len_r + 8'h01;
		else
			conv_len_r <= 8'h00;
	end

	// Checks
	chk_go_clears_done: assert property (
		@(posedge clk_i) disable iff (!reset_n_i)
		done |=> !ctrl_r[arf_pkg::CTRL_GO_BIT])
		else $error("go bit not cleared at completion");

	chk_go_starts_conv: assert property (
		@(posedge clk_i) disable iff (!reset_n_i)
		(go_set && state_r == ST_IDLE) |=> state_r == ST_CONV)
		else $error("go did not start conversion");

	chk_left_high: assert property (
		@(posedge clk_i) disable iff (!reset_n_i)
		(done && !cfg_r[arf_pkg::CFG_JUSTIFY_BIT])
		|=> res_high == $past(samp_s2_r[9:2]))
		else $error("left high wrong");

	chk_left_low: assert property (
		@(posedge clk_i) disable iff (!reset_n_i)
		(done && !cfg_r[arf_pkg::CFG_JUSTIFY_BIT])
		|=> res_low == {$past(samp_s2_r[1:0]), 6'h00})
		else $error("left low wrong");

	chk_right_high: assert property (
		@(posedge clk_i) disable iff (!reset_n_i)
		(done && cfg_r[arf_pkg::CFG_JUSTIFY_BIT])
		|=> res_high == {6'h00, $past(samp_s2_r[9:8])})
		else $error("right high wrong");

	chk_right_low: assert property (
		@(posedge clk_i) disable iff (!reset_n_i)
		(done && cfg_r[arf_pkg::CFG_JUSTIFY_BIT])
		|=> res_low == $past(samp_s2_r[7:0]))
		else $error("right low wrong");

	chk_result_hold: assert property (
		@(posedge clk_i) disable iff (!reset_n_i)
		(!done && !wr_en) |=> $stable(res_high) && $stable(res_low))
		else $error("result changed without load or write");

	chk_conv_length: assert property (
		@(posedge clk_i) disable iff (!reset_n_i)
		$rose(state_r == ST_CONV) && ctrl_r[arf_pkg::CTRL_ENABLE_BIT]
		|-> ##[1:60] state_r != ST_CONV)
		else $error("conversion too long");

	chk_one_wait: assert property (
		@(posedge clk_i) disable iff (!reset_n_i)
		$rose(avs_read_i || avs_write_i) |-> avs_waitrequest_o)
		else $error("no wait state on a new request");

	chk_rd_stands: assert property (
		@(posedge clk_i) disable iff (!reset_n_i)
		(ack_r && avs_read_i) |=> $stable(avs_readdata_o))
		else $error("read data changed after its cycle");

	chk_status_on_done: assert property (
		@(posedge clk_i) disable iff (!reset_n_i)
		done |=> irq_stat_r[arf_pkg::IRQ_DONE_BIT])
		else $error("done flag not set at completion");

	chk_status_sticky: assert property (
		@(posedge clk_i) disable iff (!reset_n_i)
		irq_stat_r[arf_pkg::IRQ_DONE_BIT] && !(wr_en
		&& avs_address_i == arf_pkg::ADDR_IRQ_STATUS)
		|=> irq_stat_r[arf_pkg::IRQ_DONE_BIT])
		else $error("done flag dropped without a clear");

	chk_cnt_in_range: assert property (
		@(posedge clk_i) disable iff (!reset_n_i)
		cnt_r <= 8'(arf_pkg::CONV_CYCLES - 1))
		else $error("conversion counter past its end");

	chk_go_idle_low: assert property (
		@(posedge clk_i) disable iff (!reset_n_i)
		state_r == ST_IDLE |-> !ctrl_r[arf_pkg::CTRL_GO_BIT])
		else $error("go bit set with no conversion");

	chk_abort_no_load: assert property (
		@(posedge clk_i) disable iff (!reset_n_i)
		(state_r == ST_CONV && !ctrl_r[arf_pkg::CTRL_ENABLE_BIT])
		|-> !res_if.load)
		else $error("aborted conversion loaded a result");

	chk_abort_idle: assert property (
		@(posedge clk_i) disable iff (!reset_n_i)
		(state_r == ST_CONV && !ctrl_r[arf_pkg::CTRL_ENABLE_BIT])
		|=> state_r == ST_IDLE)
		else $error("conversion kept running without enable");

	chk_conv_exact: assert property (
		@(posedge clk_i) disable iff (!reset_n_i)
		res_if.load |-> conv_len_r == 8'(arf_pkg::CONV_CYCLES - 1))
		else $error("conversion length wrong");

	chk_wr_high_lands: assert property (
		@(posedge clk_i) disable iff (!reset_n_i)
		(wr_en && !done && avs_address_i == arf_pkg::ADDR_RESULT_HIGH)
		|=> res_high == $past(avs_writedata_i[7:0]))
		else $error("result high write lost");

	chk_wr_low_lands: assert property (
		@(posedge clk_i) disable iff (!reset_n_i)
		(wr_en && !done && avs_address_i == arf_pkg::ADDR_RESULT_LOW)
		|=> res_low == $past(avs_writedata_i[7:0]))
		else $error("result low write lost");
endmodule : arf_top

// ===== tb_adc_result_format.sv
// Testbench for the result formatter top
`timescale 1ns/1ps
module tb_adc_result_format;
	logic clk_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic [3:0] avs_address_i = 4'h0;
	logic avs_read_i = 1'b0;
	logic avs_write_i = 1'b0;
	logic [31:0] avs_writedata_i = 32'h0;
	logic [31:0] avs_readdata_o;
	logic avs_waitrequest_o;
	logic [9:0] sample_i = 10'h000;
	logic [4:0] channel_select_o;
	logic irq_o;
	int err_total = 0;
	int checks = 0;
	int n;
	logic [31:0] rd;
	logic [9:0] s;
	logic [4:0] ch;
	logic j;
	logic m;
	logic [7:0] cv;

	always #2 clk_i = ~clk_i;

	arf_top arf_top_i (
		.clk_i(clk_i),
		.reset_n_i(reset_n_i),
		.avs_address_i(avs_address_i),
		.avs_read_i(avs_read_i),
		.avs_write_i(avs_write_i),
		.avs_writedata_i(avs_writedata_i),
		.avs_readdata_o(avs_readdata_o),
		.avs_waitrequest_o(avs_waitrequest_o),
		.sample_i(sample_i),
		.channel_select_o(channel_select_o),
		.irq_o(irq_o)
	);

	task automatic wrap_up;
		if (err_total == 0 && checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : wrap_up

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp

	// One bus transfer, held until waitrequest is seen low at an edge
	task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_i);
		avs_address_i <= a;
		avs_write_i <= wr;
		avs_read_i <= ~wr;
		avs_writedata_i <= {24'h000000, d};
		for (int k = 0; k < 50; k++) begin
			@(posedge clk_i);
			if (avs_waitrequest_o === 1'b0) begin
				rd = avs_readdata_o;
				avs_read_i <= 1'b0;
				avs_write_i <= 1'b0;
				return;
			end
		end
		err_total++;
		$display("ERROR %0t: bus timeout", $time);
		wrap_up();
	endtask : bus

	task automatic rdc(input logic [3:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00);
		cmp(rd, {24'h000000, e});
	endtask : rdc

	function automatic logic [7:0] fmt(input logic [9:0] v, input logic jr,
		input logic hi);
		if (jr) begin
			return hi ? {6'h00, v[9:8]} : v[7:0];
		end
		return hi ? v[9:2] : {v[1:0], 6'h00};
	endfunction : fmt

	initial begin
		void'($urandom(5));
		repeat (12) @(posedge clk_i);
		reset_n_i <= 1'b1;
		rdc(arf_pkg::ADDR_CONTROL, 8'h00);
		rdc(4'h6, 8'h00);
		for (int i = 0; i < 10; i++) begin
			s = (i < 4) ? (i[1] ? 10'h000 : 10'h3ff) : 10'($urandom);
			ch = 5'($urandom);
			j = i[0];
			m = (i < 8);
			sample_i <= s;
			bus(1'b1, arf_pkg::ADDR_IRQ_MASK, {7'h00, m});
			cv = {j, 7'($urandom)};
			bus(1'b1, arf_pkg::ADDR_CONFIG, cv);
			rdc(arf_pkg::ADDR_CONFIG, cv & arf_pkg::CFG_WRITE_MASK);
			bus(1'b1, arf_pkg::ADDR_CONTROL, {1'b0, ch, 2'b01});
			// Acquisition wait after channel change
			repeat (20) @(posedge clk_i);
			cmp({27'h0, channel_select_o}, {27'h0, ch});
			bus(1'b1, arf_pkg::ADDR_CONTROL, {1'b0, ch, 2'b11});
			n = 0;
			do begin
				bus(1'b0, arf_pkg::ADDR_CONTROL, 8'h00);
				n++;
			end while (rd[1] !== 1'b0 && n < 100);
			if (n >= 100) begin
				err_total++;
				$display("ERROR %0t: conversion never ended", $time);
				wrap_up();
			end
			cmp(rd, {24'h000000, 1'b0, ch, 2'b01});
			cmp({31'h0, irq_o}, {31'h0, m});
			rdc(arf_pkg::ADDR_RESULT_HIGH, fmt(s, j, 1'b1));
			rdc(arf_pkg::ADDR_RESULT_LOW, fmt(s, j, 1'b0));
			rdc(arf_pkg::ADDR_IRQ_STATUS, 8'h01);
			bus(1'b1, arf_pkg::ADDR_IRQ_STATUS, 8'h01);
			rdc(arf_pkg::ADDR_IRQ_STATUS, 8'h00);
		end
		bus(1'b1, arf_pkg::ADDR_RESULT_HIGH, 8'ha5);
		bus(1'b1, arf_pkg::ADDR_RESULT_LOW, 8'h5a);
		rdc(arf_pkg::ADDR_RESULT_HIGH, 8'ha5);
		rdc(arf_pkg::ADDR_RESULT_LOW, 8'h5a);
		// Mid-run reset keeps the result pair
		reset_n_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		reset_n_i <= 1'b1;
		rdc(arf_pkg::ADDR_RESULT_HIGH, 8'ha5);
		rdc(arf_pkg::ADDR_RESULT_LOW, 8'h5a);
		rdc(arf_pkg::ADDR_CONTROL, 8'h00);
		// Clearing enable mid-conversion aborts with no load
		bus(1'b1, arf_pkg::ADDR_CONTROL, {1'b0, ch, 2'b01});
		repeat (20) @(posedge clk_i);
		bus(1'b1, arf_pkg::ADDR_CONTROL, {1'b0, ch, 2'b11});
		repeat (10) @(posedge clk_i);
		bus(1'b1, arf_pkg::ADDR_CONTROL, {1'b0, ch, 2'b00});
		repeat (60) @(posedge clk_i);
		rdc(arf_pkg::ADDR_CONTROL, {1'b0, ch, 2'b00});
		rdc(arf_pkg::ADDR_IRQ_STATUS, 8'h00);
		rdc(arf_pkg::ADDR_RESULT_LOW, 8'h5a);
		// Start without enable must not convert
		bus(1'b1, arf_pkg::ADDR_CONTROL, 8'h02);
		repeat (60) @(posedge clk_i);
		rdc(arf_pkg::ADDR_IRQ_STATUS, 8'h00);
		rdc(arf_pkg::ADDR_CONTROL, 8'h00);
		rdc(arf_pkg::ADDR_RESULT_HIGH, 8'ha5);
		wrap_up();
	end
endmodule : tb_adc_result_format
